// ===== hw/pifb_regs.svh
// Purpose: offsets, field positions and reset values of the flag bank
// Assumes: byte addressing on a 32-bit register bus
// Notes: printed offsets are not all multiples of four, so they are indices
`ifndef PIFB_REGS_SVH
`define PIFB_REGS_SVH
`define PIFB_IDX_FLAGS 8'h10
`define PIFB_IDX_ENABLES 8'h11
`define PIFB_IDX_WAKE 8'h12
`define PIFB_IDX_IRQ_STATUS 8'h13
`define PIFB_IDX_IRQ_MASK 8'h14
`define PIFB_BIT_SERIAL 7
`define PIFB_BIT_COLLISION 6
`define PIFB_BIT_CONVERTER 5
`define PIFB_BIT_CAPTURE4 3
`define PIFB_BIT_CAPTURE3 2
`define PIFB_BIT_TX_EMPTY 1
`define PIFB_BIT_RX_FULL 0
`define PIFB_FLAGS_RESET 8'h02
`define PIFB_ENABLES_RESET 8'h00
`define PIFB_IMPL_MASK 8'hEF
`define PIFB_LATCH_MASK 8'hEC
`define PIFB_WAKE_RESET 2'h0
`define PIFB_IRQ_RESET 2'h0
`define PIFB_VECTOR_ADDR 16'h0020
`endif

// ===== hw/pifb_pkg.sv
// Purpose: types shared by the flag bank and its bench
// Assumes: nothing beyond the register header
// Notes: event pulses travel as one struct
package pifb_pkg;
    typedef struct packed {
        logic spi_byte_done;
        logic i2c_byte_done;
        logic i2c_seq_done;
        logic i2c_idle_start_stop;
        logic collision;
        logic conv_done;
        logic capture4;
        logic capture3;
    } pifb_events_t;

    typedef enum logic [1:0] {
        PIFB_MODE_SPI = 2'h0,
        PIFB_MODE_I2C_SLAVE = 2'h1,
        PIFB_MODE_I2C_MASTER = 2'h2,
        PIFB_MODE_OFF = 2'h3
    } pifb_port_mode_t;

    typedef enum logic [1:0] {
        PIFB_ST_IDLE = 2'b01,
        PIFB_ST_RESP = 2'b10
    } pifb_bus_state_t;
endpackage

// ===== hw/pifb_flag_bank.sv
// Purpose: second peripheral event flag bank with enables and wake logic
// Assumes: event pulses and buffer levels come from logic on aclk
// Notes: AXI4-Lite slave; one write and one read at a time
//
// Contract
// - set serial flag on SPI byte done
// - set serial flag on I2C byte done
// - set serial flag on master sequence done
// - set serial flag on idle start/stop
// - set collision flag in I2C master mode
// - set converter flag at conversion end only
// - set capture channel four flag on event
// - set capture channel three flag on event
// - transmit flag reads one while buffer empty
// - receive flag reads one while buffer full
// - unimplemented bits read zero, ignore writes
// - wake sets cause flag, others keep
// - wake with interrupts enabled loads vector
`timescale 1ns/1ps
`include "pifb_regs.svh"

module pifb_flag_bank (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pifb_pkg::pifb_events_t events,
    input wire pifb_pkg::pifb_port_mode_t port_mode,
    input wire logic port_idle,
    input wire logic conv_busy,
    input wire logic usart2_tx_buf_full,
    input wire logic usart2_rx_buf_full,
    input wire logic sleeping,
    input wire logic global_interrupt_disable,
    output logic periph_irq_req,
    output logic wake_req,
    output logic vector_load,
    output logic [15:0] vector_addr,
    output logic irq
);
    import pifb_pkg::*;

    function automatic logic hit(input logic [31:0] addr, input logic [7:0] idx);
        hit = (addr[31:2] == {22'h0, idx}) ;
    endfunction

    // off counts as neither mode, so bus events are dropped while the port is off
    function automatic logic is_i2c(input pifb_port_mode_t mode);
        is_i2c = (mode == PIFB_MODE_I2C_SLAVE) || (mode == PIFB_MODE_I2C_MASTER);
    endfunction

    logic [7:0] flags_ff, nxt_flags;
    logic [7:0] enables_ff, nxt_enables;
    logic [1:0] wake_ff, nxt_wake;
    logic [1:0] irq_stat_ff, nxt_irq_stat;
    logic [1:0] irq_mask_ff, nxt_irq_mask;
    logic req_ff, nxt_req;
    logic wake_req_ff, nxt_wake_req;
    logic vec_ff, nxt_vec;
    logic irq_ff, nxt_irq;
    logic awready_ff, nxt_awready;
    logic wready_ff, nxt_wready;
    logic arready_ff, nxt_arready;
    logic bvalid_ff, nxt_bvalid;
    logic rvalid_ff, nxt_rvalid;

    logic aw_held_ff, nxt_aw_held;
    logic w_held_ff, nxt_w_held;
    logic [31:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    pifb_bus_state_t wst_ff, nxt_wst;
    pifb_bus_state_t rst_ff, nxt_rst;
    logic [1:0] bresp_ff, nxt_bresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;

    logic [7:0] set_ev;
    logic [7:0] status;
    logic do_write;
    logic map_hit;

    // buffer-level bits are live, not latched
    always_comb begin
        status = flags_ff & `PIFB_LATCH_MASK;
        status[`PIFB_BIT_TX_EMPTY] = ~usart2_tx_buf_full;
        status[`PIFB_BIT_RX_FULL] = usart2_rx_buf_full;
    end

    always_comb begin
        set_ev = 8'h00;
        set_ev[`PIFB_BIT_SERIAL] = (events.spi_byte_done && port_mode == PIFB_MODE_SPI)
            || (events.i2c_byte_done && is_i2c(port_mode))
            || (events.i2c_seq_done && port_mode == PIFB_MODE_I2C_MASTER)
            || (events.i2c_idle_start_stop && port_idle && is_i2c(port_mode));
        set_ev[`PIFB_BIT_COLLISION] = events.collision && port_mode == PIFB_MODE_I2C_MASTER;
        // a done pulse during a running conversion is ignored
        set_ev[`PIFB_BIT_CONVERTER] = events.conv_done && !conv_busy;
        set_ev[`PIFB_BIT_CAPTURE4] = events.capture4;
        set_ev[`PIFB_BIT_CAPTURE3] = events.capture3;
    end

    // bus slave
    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_w_held = w_held_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_wst = wst_ff;
        nxt_bresp = bresp_ff;
        nxt_rst = rst_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        do_write = 1'b0;
        map_hit = 1'b0;
        if (s_axi_awvalid && !aw_held_ff && wst_ff == PIFB_ST_IDLE) begin
            nxt_aw_held = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_ff && wst_ff == PIFB_ST_IDLE) begin
            nxt_w_held = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        case (wst_ff)
            PIFB_ST_IDLE: begin
                if (aw_held_ff && w_held_ff) begin
                    do_write = 1'b1;
                    map_hit = hit(awaddr_ff, `PIFB_IDX_FLAGS) || hit(awaddr_ff, `PIFB_IDX_ENABLES)
                        || hit(awaddr_ff, `PIFB_IDX_WAKE) || hit(awaddr_ff, `PIFB_IDX_IRQ_STATUS)
                        || hit(awaddr_ff, `PIFB_IDX_IRQ_MASK);
                    nxt_bresp = map_hit ? 2'h0 : 2'h3;
                    nxt_aw_held = 1'b0;
                    nxt_w_held = 1'b0;
                    nxt_wst = PIFB_ST_RESP;
                end
            end
            PIFB_ST_RESP: begin
                if (s_axi_bready) begin
                    nxt_wst = PIFB_ST_IDLE;
                end
            end
            default: nxt_wst = PIFB_ST_IDLE;
        endcase
        case (rst_ff)
            PIFB_ST_IDLE: begin
                if (s_axi_arvalid) begin
                    nxt_rst = PIFB_ST_RESP;
                    nxt_rresp = 2'h0;
                    nxt_rdata = 32'h0000_0000;
                    if (hit(s_axi_araddr, `PIFB_IDX_FLAGS)) begin
                        nxt_rdata = {24'h0, status & `PIFB_IMPL_MASK};
                    end else if (hit(s_axi_araddr, `PIFB_IDX_ENABLES)) begin
                        nxt_rdata = {24'h0, enables_ff};
                    end else if (hit(s_axi_araddr, `PIFB_IDX_WAKE)) begin
                        nxt_rdata = {30'h0, wake_ff};
                    end else if (hit(s_axi_araddr, `PIFB_IDX_IRQ_STATUS)) begin
                        nxt_rdata = {30'h0, irq_stat_ff};
                    end else if (hit(s_axi_araddr, `PIFB_IDX_IRQ_MASK)) begin
                        nxt_rdata = {30'h0, irq_mask_ff};
                    end else begin
                        nxt_rresp = 2'h3;
                    end
                end
            end
            PIFB_ST_RESP: begin
                if (s_axi_rready) begin
                    nxt_rst = PIFB_ST_IDLE;
                end
            end
            default: nxt_rst = PIFB_ST_IDLE;
        endcase
        // handshake lines follow the next slot state, so the ports leave flops directly
        nxt_awready = !nxt_aw_held && nxt_wst == PIFB_ST_IDLE;
        nxt_wready = !nxt_w_held && nxt_wst == PIFB_ST_IDLE;
        nxt_bvalid = nxt_wst == PIFB_ST_RESP;
        nxt_arready = nxt_rst == PIFB_ST_IDLE;
        nxt_rvalid = nxt_rst == PIFB_ST_RESP;
    end

    // register and flag updates; hardware set wins over software clear
    always_comb begin
        logic [7:0] pend;
        logic wake_now;
        pend = 8'h00;
        wake_now = 1'b0;
        nxt_flags = flags_ff;
        nxt_enables = enables_ff;
        nxt_wake = wake_ff;
        nxt_irq_stat = irq_stat_ff;
        nxt_irq_mask = irq_mask_ff;
        if (do_write && wstrb_ff[0]) begin
            if (hit(awaddr_ff, `PIFB_IDX_FLAGS)) begin
                // writing zero clears; writing one may set, as on the core
                nxt_flags = (flags_ff & ~`PIFB_LATCH_MASK)
                    | (wdata_ff[7:0] & `PIFB_LATCH_MASK);
            end
            if (hit(awaddr_ff, `PIFB_IDX_ENABLES)) begin
                nxt_enables = wdata_ff[7:0] & `PIFB_IMPL_MASK;
            end
            if (hit(awaddr_ff, `PIFB_IDX_WAKE)) begin
                nxt_wake = wdata_ff[1:0];
            end
            if (hit(awaddr_ff, `PIFB_IDX_IRQ_STATUS)) begin
                nxt_irq_stat = irq_stat_ff & ~wdata_ff[1:0];
            end
            if (hit(awaddr_ff, `PIFB_IDX_IRQ_MASK)) begin
                nxt_irq_mask = wdata_ff[1:0];
            end
        end
        // only flags with a cause are touched, others keep their value
        nxt_flags = nxt_flags | set_ev;
        pend = ((nxt_flags & `PIFB_LATCH_MASK) | (status & ~`PIFB_LATCH_MASK)) & enables_ff;
        nxt_req = |pend;
        wake_now = sleeping && nxt_req && wake_ff[0];
        nxt_wake_req = wake_now;
        nxt_vec = wake_now && !global_interrupt_disable;
        nxt_irq_stat[0] = nxt_irq_stat[0] | (nxt_req & ~req_ff);
        nxt_irq_stat[1] = nxt_irq_stat[1] | wake_now;
        nxt_irq = |(nxt_irq_stat & irq_mask_ff);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_ff <= `PIFB_FLAGS_RESET;
            enables_ff <= `PIFB_ENABLES_RESET;
            wake_ff <= `PIFB_WAKE_RESET;
            irq_stat_ff <= `PIFB_IRQ_RESET;
            irq_mask_ff <= `PIFB_IRQ_RESET;
            req_ff <= 1'b0;
            wake_req_ff <= 1'b0;
            vec_ff <= 1'b0;
            irq_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            arready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 32'h0000_0000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            wst_ff <= PIFB_ST_IDLE;
            rst_ff <= PIFB_ST_IDLE;
            bresp_ff <= 2'h0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= 2'h0;
        end else if (clk_en) begin
            flags_ff <= nxt_flags;
            enables_ff <= nxt_enables;
            wake_ff <= nxt_wake;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            req_ff <= nxt_req;
            wake_req_ff <= nxt_wake_req;
            vec_ff <= nxt_vec;
            irq_ff <= nxt_irq;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            arready_ff <= nxt_arready;
            bvalid_ff <= nxt_bvalid;
            rvalid_ff <= nxt_rvalid;
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            wst_ff <= nxt_wst;
            rst_ff <= nxt_rst;
            bresp_ff <= nxt_bresp;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // ready lines are flops: high while the channel slot is free
    always_comb begin
        s_axi_awready = awready_ff;
        s_axi_wready = wready_ff;
        s_axi_bvalid = bvalid_ff;
        s_axi_bresp = bresp_ff;
        s_axi_arready = arready_ff;
        s_axi_rvalid = rvalid_ff;
        s_axi_rdata = rdata_ff;
        s_axi_rresp = rresp_ff;
        periph_irq_req = req_ff;
        wake_req = wake_req_ff;
        vector_load = vec_ff;
        vector_addr = `PIFB_VECTOR_ADDR;
        irq = irq_ff;
    end
endmodule

// ===== tb/pifb_chk.sv
// Purpose: port-level checks for the flag bank
// Assumes: clk_en high whenever these matter
// Notes: flags are internal, so checks key on wake, vector and bus outputs
`timescale 1ns/1ps
module pifb_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic sleeping,
    input wire logic global_interrupt_disable,
    input wire logic periph_irq_req,
    input wire logic wake_req,
    input wire logic vector_load
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_vector_needs_wake: assert property (vector_load |-> wake_req || $past(wake_req))
        else $error("vector load without wake");
    a_vector_gid_clear: assert property (vector_load |-> !$past(global_interrupt_disable))
        else $error("vector load while interrupts disabled");
    a_wake_from_sleep: assert property (wake_req |-> $past(sleeping))
        else $error("wake request while awake");
    a_wake_has_cause: assert property (wake_req |-> periph_irq_req || $past(periph_irq_req))
        else $error("wake request without interrupt request");
    a_read_answer: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while read pending");
    cover property (vector_load);
    cover property (wake_req && global_interrupt_disable);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind pifb_flag_bank pifb_chk i_pifb_chk (.aclk, .aresetn, .clk_en, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .sleeping, .global_interrupt_disable,
    .periph_irq_req, .wake_req, .vector_load);

// ===== tb/pifb_event_src.sv
// Purpose: peripheral event sources beside the flag bank
// Assumes: one command cycle gives one event cycle
// Notes: sources never hold a pulse, so a missed edge is lost
`timescale 1ns/1ps
module pifb_event_src (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic fire,
    input wire pifb_pkg::pifb_events_t cmd,
    output pifb_pkg::pifb_events_t events
);
    import pifb_pkg::*;
    pifb_events_t events_ff;
    pifb_events_t nxt_events;
    always_comb begin
        nxt_events = fire ? cmd : '0;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            events_ff <= '0;
        end else begin
            events_ff <= nxt_events;
        end
    end
    assign events = events_ff;
endmodule

// ===== tb/peripheral_irq_flag_bank_two_bench.sv
// Purpose: self-checking bench for the flag bank
// Assumes: flags read back through the register bus
// Notes: each scenario clears the flags it raised
`timescale 1ns/1ps
`include "pifb_regs.svh"
module peripheral_irq_flag_bank_two_bench;
    import pifb_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_rvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_arready, port_idle, conv_busy, tx_full, rx_full;
    logic sleeping, gid, fire, periph_irq_req, wake_req, vector_load, irq, vl;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, wb;
    logic [15:0] vector_addr;
    pifb_events_t events, cmd;
    pifb_port_mode_t port_mode;
    int fails, checks_done, cyc;
    logic [7:0] ex [8] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h40, 8'h20, 8'h08, 8'h04};
    logic [1:0] md [8] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0};
    pifb_flag_bank i_pifb_flag_bank (.aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .events, .port_mode, .port_idle, .conv_busy,
        .usart2_tx_buf_full(tx_full), .usart2_rx_buf_full(rx_full), .sleeping,
        .global_interrupt_disable(gid), .periph_irq_req, .wake_req, .vector_load, .vector_addr, .irq);
    pifb_event_src i_pifb_event_src (.aclk, .aresetn, .fire, .cmd, .events);
    initial begin
        aclk = 0;
        forever #4 aclk = ~aclk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic done;
        done = 0;
        s_axi_awaddr <= {22'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // ready stays up after the answer; dropping it would clash with the next call's raise
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                done = 1;
                wb = s_axi_bresp;
            end
        end
    endtask
    task automatic rd(input logic [7:0] idx);
        logic done;
        done = 0;
        s_axi_araddr <= {22'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                done = 1;
                rv = s_axi_rdata;
                rr = s_axi_rresp;
            end
        end
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] e, input string nm);
        rd(idx);
        chk(nm, {24'h0, e}, rv);
        chk("read response", 32'h0, {30'h0, rr});
    endtask
    task automatic pulse(input logic [7:0] c);
        cmd <= pifb_events_t'(c);
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic t_bits();
        rdc(`PIFB_IDX_FLAGS, 8'h02, "flags after reset");
        rdc(`PIFB_IDX_ENABLES, 8'h00, "enables after reset");
        wr(`PIFB_IDX_FLAGS, 8'hFF);
        rdc(`PIFB_IDX_FLAGS, 8'hEE, "flags all written");
        wr(`PIFB_IDX_FLAGS, 8'h00);
        rdc(`PIFB_IDX_FLAGS, 8'h02, "flags cleared");
        wr(`PIFB_IDX_ENABLES, 8'hFF);
        rdc(`PIFB_IDX_ENABLES, 8'hEF, "enables all written");
        wr(`PIFB_IDX_ENABLES, 8'h04);
        chk("write response", 32'h0, {30'h0, wb});
        rd(8'h20);
        chk("unmapped response", 32'h3, {30'h0, rr});
        wr(8'h20, 8'h00);
        chk("unmapped write response", 32'h3, {30'h0, wb});
    endtask
    task automatic t_events();
        for (int i = 0; i < 8; i++) begin
            port_mode <= pifb_port_mode_t'(md[i]);
            port_idle <= (i == 3);
            pulse(8'h80 >> i);
            rdc(`PIFB_IDX_FLAGS, ex[i] | 8'h02, "event flag");
            wr(`PIFB_IDX_FLAGS, 8'h00);
        end
        port_mode <= PIFB_MODE_OFF;
        port_idle <= 1'b1;
        pulse(8'hF8);
        rdc(`PIFB_IDX_FLAGS, 8'h02, "port off events");
        port_mode <= PIFB_MODE_SPI;
        port_idle <= 1'b0;
        conv_busy <= 1'b1;
        pulse(8'h0C);
        rdc(`PIFB_IDX_FLAGS, 8'h02, "busy or non-master event");
        conv_busy <= 1'b0;
        tx_full <= 1'b1;
        rx_full <= 1'b1;
        rdc(`PIFB_IDX_FLAGS, 8'h01, "buffer levels");
        tx_full <= 1'b0;
        rx_full <= 1'b0;
    endtask
    task automatic t_irq();
        wr(`PIFB_IDX_IRQ_MASK, 8'h00);
        pulse(8'h01);
        rdc(`PIFB_IDX_IRQ_STATUS, 8'h01, "request edge status");
        chk("request", 32'h1, {31'h0, periph_irq_req});
        chk("masked irq", 32'h0, {31'h0, irq});
        wr(`PIFB_IDX_IRQ_MASK, 8'h01);
        @(posedge aclk);
        chk("unmasked irq", 32'h1, {31'h0, irq});
        wr(`PIFB_IDX_FLAGS, 8'h00);
        wr(`PIFB_IDX_IRQ_STATUS, 8'h01);
        @(posedge aclk);
        chk("request cleared", 32'h0, {31'h0, periph_irq_req});
        chk("irq cleared", 32'h0, {31'h0, irq});
    endtask
    task automatic t_wake(input logic g);
        wr(`PIFB_IDX_WAKE, 8'h01);
        gid <= g;
        sleeping <= 1'b1;
        pulse(8'h01);
        vl = 0;
        repeat (8) begin
            @(posedge aclk);
            vl = vl | vector_load;
        end
        sleeping <= 1'b0;
        chk("vector load", {31'h0, !g}, {31'h0, vl});
        chk("vector address", {16'h0, `PIFB_VECTOR_ADDR}, {16'h0, vector_addr});
        rdc(`PIFB_IDX_FLAGS, 8'h06, "flags after wake");
        wr(`PIFB_IDX_FLAGS, 8'h00);
        rdc(`PIFB_IDX_IRQ_STATUS, 8'h03, "wake status");
        wr(`PIFB_IDX_IRQ_STATUS, 8'h03);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, fire} = '0;
        {port_idle, conv_busy, tx_full, rx_full, sleeping, gid} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        cmd = '0;
        port_mode = PIFB_MODE_SPI;
        fails = 0;
        checks_done = 0;
        cyc = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_bits();
        t_events();
        t_irq();
        t_wake(1'b0);
        t_wake(1'b1);
        summarize();
    end
endmodule
